//--- pin_sync.sv
// two-flop synchroniser for pins arriving from outside the bus clock
// assumes inputs are quasi-static relative to the 25 ns clock
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1_ff;
   logic [W-1:0] stage2_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1_ff <= '1;
         stage2_ff <= '1;
      end else begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_out = stage2_ff;
endmodule : pin_sync

//--- rx_buffer.sv
// two-entry receive buffer; head entry is a register
// assumes the writer never pushes into a full buffer without a pop
`timescale 1ns/10ps
module rx_buffer (
   input  wire logic clk,
   input  wire logic rst_b,
   rx_buffer_if.store bif
);
   logic [$bits(bif.push_word)-1:0] ent0_ff;
   logic [$bits(bif.push_word)-1:0] ent1_ff;
   logic                            v0_ff;
   logic                            v1_ff;
   logic                            do_pop;

   assign do_pop = bif.pop && v0_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ent0_ff <= '0;
         ent1_ff <= '0;
         v0_ff   <= 1'b0;
         v1_ff   <= 1'b0;
      end else if (bif.flush) begin
         v0_ff <= 1'b0;
         v1_ff <= 1'b0;
      end else if (do_pop && bif.push) begin
         if (v1_ff) begin
            ent0_ff <= ent1_ff;
            ent1_ff <= bif.push_word;
         end else begin
            ent0_ff <= bif.push_word;
         end
      end else if (do_pop) begin
         ent0_ff <= ent1_ff;
         v0_ff   <= v1_ff;
         v1_ff   <= 1'b0;
      end else if (bif.push) begin
         if (!v0_ff) begin
            ent0_ff <= bif.push_word;
            v0_ff   <= 1'b1;
         end else if (!v1_ff) begin
            ent1_ff <= bif.push_word;
            v1_ff   <= 1'b1;
         end
      end
   end

   assign bif.head_word  = ent0_ff;
   assign bif.head_valid = v0_ff;
   assign bif.full       = v1_ff;
endmodule : rx_buffer

//--- rx_buffer_if.sv
// push/pop carrier between the link logic and the receive buffer
// assumes both ends on the bus clock
`timescale 1ns/10ps
interface rx_buffer_if #(parameter int W = 9);
   logic         push;
   logic [W-1:0] push_word;
   logic         pop;
   logic         flush;
   logic [W-1:0] head_word;
   logic         head_valid;
   logic         full;

   modport ctrl  (output push, push_word, pop, flush, input head_word, head_valid, full);
   modport store (input push, push_word, pop, flush, output head_word, head_valid, full);
endinterface : rx_buffer_if

//--- spi_master_model.sv
// behavioural master: mode 0, msb first, 200 ns serial clock
// assumes the slave drives data out 4 bus clocks after a clock edge
`timescale 1ns/10ps
module spi_master_model (
   output logic       ss_b_pin,
   output logic       sck_pin,
   output logic       mosi_pin,
   input  wire logic  miso_o,
   input  wire logic  miso_oe,
   output logic [7:0] rx_byte,
   output logic       rx_stb
);
   initial begin
      ss_b_pin = 1'b1;
      sck_pin  = 1'b0;
      mosi_pin = 1'b0;
      rx_byte  = 8'h00;
      rx_stb   = 1'b0;
   end
   // clock stands low between frames; the 7 ns offset keeps pin edges off clk edges
   task automatic frame(input int n, input logic [23:0] tx);
      logic [7:0] r;
      #7 ss_b_pin = 1'b0;
      #200;
      for (int c = 0; c < n; c++) begin
         for (int b = 7; b >= 0; b--) begin
            mosi_pin = tx[8*(2-c)+b];
            #100 sck_pin = 1'b1;
            r[b] = miso_oe ? miso_o : 1'bx;
            #100 sck_pin = 1'b0;
         end
         rx_byte = r;
         rx_stb  = 1'b1;
         #25 rx_stb = 1'b0;
      end
      #100 ss_b_pin = 1'b1;
      mosi_pin = ~mosi_pin;
      #400;
   endtask : frame
endmodule : spi_master_model

//--- spi_slave_link.sv
// serial slave: shift engine, transmit holding buffer, flags and overflow handling
// assumes select, serial clock and data in are asynchronous pins, all else on clk
`timescale 1ns/10ps
module spi_slave_link (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [2:0]  operating_mode_field,
   input  wire logic        clock_polarity,
   input  wire logic        clock_phase,
   input  wire logic        lsb_first,
   input  wire logic        immediate_overflow_notify,
   input  wire logic        rx_enable,
   // software side strobes, one clock each
   input  wire logic        data_wr,
   input  wire logic [7:0]  data_wdata,
   input  wire logic        data_rd,
   input  wire logic        tx_done_clear,
   input  wire logic        overflow_clear,
   input  wire logic        error_clear,
   // link pins, asynchronous to clk
   input  wire logic        ss_b_pin,
   input  wire logic        sck_pin,
   input  wire logic        mosi_pin,
   // pin drive and status, all straight from flip-flops
   output logic             miso_o,
   output logic             miso_oe,
   output logic [7:0]       rx_data,
   output logic             tx_register_empty_flag,
   output logic             receive_complete_flag,
   output logic             transmit_complete_flag,
   output logic             receive_overflow_status,
   output logic             error_flag
);
   localparam int CB = spi_slave_pkg::CHAR_BITS;

   function automatic logic [2:0] bit_pos(input logic [2:0] cnt, input logic lsb);
      bit_pos = lsb ? cnt : (spi_slave_pkg::LAST_BIT - cnt);
   endfunction : bit_pos

   function automatic logic [CB-1:0] shift_in(input logic [CB-1:0] sr, input logic b,
                                              input logic lsb);
      shift_in = lsb ? {b, sr[CB-1:1]} : {sr[CB-2:0], b};
   endfunction : shift_in

   // synchronised pins
   logic [2:0] pins_s;
   logic       ss_b_s;
   logic       sck_s;
   logic       mosi_s;

   pin_sync #(.W(3)) u_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in ({ss_b_pin, sck_pin, mosi_pin}),
      .sync_out (pins_s)
   );
   assign ss_b_s = pins_s[2];
   assign sck_s  = pins_s[1];
   assign mosi_s = pins_s[0];

   rx_buffer_if #(.W(spi_slave_pkg::ENTRY_BITS)) bif ();

   rx_buffer u_rxbuf (
      .clk   (clk),
      .rst_b (rst_b),
      .bif   (bif)
   );

   spi_slave_pkg::link_state_e state_ff;
   spi_slave_pkg::link_state_e nxt_state;
   logic                       sck_q_ff;
   logic [2:0]                 bit_cnt_ff;
   logic [CB-1:0]              rx_sr_ff;
   logic [CB-1:0]              tx_sr_ff;
   logic [CB-1:0]              hold_ff;
   logic                       hold_full_ff;
   logic [1:0]                 sck_since_wr_ff;
   logic [1:0]                 empty_dly_ff;
   logic                       pend_ovf_ff;
   logic                       miso_ff;
   logic                       miso_oe_ff;
   logic [CB-1:0]              rx_data_ff;
   logic                       empty_ff;
   logic                       rx_done_ff;
   logic                       tx_done_ff;
   logic                       ovf_ff;
   logic                       err_ff;

   logic          slave_sel;
   logic          active;
   logic          sck_rise;
   logic          sck_fall;
   logic          lead_edge;
   logic          sample_ev;
   logic          char_done;
   logic [CB-1:0] rx_char;
   logic          load_ok;
   logic          rx_push;
   logic          overflow;
   logic          marker_push;
   logic          fifo_pop;
   logic          head_mark;
   logic          txn_end;

   assign slave_sel = (operating_mode_field == spi_slave_pkg::MODE_SLAVE);
   assign active    = (state_ff == spi_slave_pkg::LINK_ACTIVE);
   assign sck_rise  = sck_s && !sck_q_ff;
   assign sck_fall  = !sck_s && sck_q_ff;
   assign lead_edge = active && (clock_polarity ? sck_fall : sck_rise);
   // mode 0/2 sample on the leading edge, mode 1/3 on the trailing one
   assign sample_ev = active && ((clock_phase ^ clock_polarity) ? sck_fall : sck_rise);
   assign char_done = sample_ev && (bit_cnt_ff == spi_slave_pkg::LAST_BIT);
   assign rx_char   = shift_in(rx_sr_ff, mosi_s, lsb_first);
   assign load_ok   = hold_full_ff && (sck_since_wr_ff == spi_slave_pkg::TX_LOAD_SCK);
   assign txn_end   = active && ss_b_s;

   // receive buffer traffic
   assign fifo_pop    = data_rd && bif.head_valid;
   assign head_mark   = bif.head_word[CB];
   assign rx_push     = char_done && rx_enable;
   assign overflow    = rx_push && bif.full && !fifo_pop;
   // a deferred marker takes the slot freed by a read, but never beats a character
   assign marker_push = pend_ovf_ff && fifo_pop && !rx_push;
   assign bif.push      = (rx_push && !overflow) || marker_push;
   assign bif.push_word = rx_push ? {1'b0, rx_char} : {1'b1, spi_slave_pkg::MARK_DATA};
   assign bif.pop       = fifo_pop;
   assign bif.flush     = !rx_enable;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         spi_slave_pkg::LINK_IDLE: begin
            if (slave_sel && !ss_b_s) begin
               nxt_state = spi_slave_pkg::LINK_ACTIVE;
            end
         end
         spi_slave_pkg::LINK_ACTIVE: begin
            if (ss_b_s || !slave_sel) begin
               nxt_state = spi_slave_pkg::LINK_IDLE;
            end
         end
         default: nxt_state = spi_slave_pkg::LINK_IDLE;
      endcase
   end

   // link state and bit counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff   <= spi_slave_pkg::LINK_IDLE;
         sck_q_ff   <= 1'b0;
         bit_cnt_ff <= 3'h0;
         rx_sr_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         sck_q_ff <= sck_s;
         if (!active) begin
            bit_cnt_ff <= 3'h0;
         end else if (sample_ev) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            rx_sr_ff   <= rx_char;
         end
      end
   end

   // transmit shifter: loads at each character boundary
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_sr_ff <= '0;
      end else if (char_done) begin
         // late or missing data: echo what was just received
         // echoing keeps the line defined rather than resending stale data
         if (load_ok) begin
            tx_sr_ff <= hold_ff;
         end else begin
            tx_sr_ff <= rx_char;
         end
      end
   end

   // pin outputs; bit shown is the one the master samples next
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         miso_ff    <= 1'b0;
         miso_oe_ff <= 1'b0;
      end else begin
         miso_ff    <= tx_sr_ff[bit_pos(bit_cnt_ff, lsb_first)];
         miso_oe_ff <= (nxt_state == spi_slave_pkg::LINK_ACTIVE);
      end
   end

   // transmit holding buffer and its readiness count in serial clocks
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_ff         <= '0;
         hold_full_ff    <= 1'b0;
         sck_since_wr_ff <= 2'h0;
      end else if (data_wr) begin
         hold_ff         <= data_wdata;
         hold_full_ff    <= 1'b1;
         sck_since_wr_ff <= 2'h0;
      end else begin
         if (char_done && load_ok) begin
            hold_full_ff <= 1'b0;
         end
         if (lead_edge && hold_full_ff && sck_since_wr_ff != spi_slave_pkg::TX_LOAD_SCK) begin
            sck_since_wr_ff <= sck_since_wr_ff + 2'h1;
         end
      end
   end

   // empty flag: cleared by a write, set a fixed delay after the load
   // the set wins over a coincident write, so a load is never hidden
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         empty_dly_ff <= 2'h0;
         empty_ff     <= 1'b1;
      end else begin
         if (char_done && load_ok) begin
            empty_dly_ff <= spi_slave_pkg::EMPTY_DELAY_CLKS;
         end else if (empty_dly_ff != 2'h0) begin
            empty_dly_ff <= empty_dly_ff - 2'h1;
         end
         if (empty_dly_ff == spi_slave_pkg::EMPTY_FIRE) begin
            empty_ff <= 1'b1;
         end else if (data_wr) begin
            empty_ff <= 1'b0;
         end
      end
   end

   // transaction end
   // not gated by the holding buffer: any select rise while active ends it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_done_ff <= 1'b0;
      end else if (txn_end) begin
         tx_done_ff <= 1'b1;
      end else if (tx_done_clear) begin
         tx_done_ff <= 1'b0;
      end
   end

   // read side of the receive buffer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_data_ff <= '0;
         rx_done_ff <= 1'b0;
      end else begin
         if (fifo_pop) begin
            rx_data_ff <= head_mark ? spi_slave_pkg::MARK_DATA : bif.head_word[CB-1:0];
         end
         // one clock behind occupancy; software polls between reads
         rx_done_ff <= bif.head_valid;
      end
   end

   // overflow: immediate or deferred through the buffer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_ovf_ff <= 1'b0;
         ovf_ff      <= 1'b0;
         err_ff      <= 1'b0;
      end else begin
         if (!rx_enable || marker_push) begin
            pend_ovf_ff <= 1'b0;
         end else if (overflow && !immediate_overflow_notify) begin
            pend_ovf_ff <= 1'b1;
         end
         if (!rx_enable) begin
            ovf_ff <= 1'b0;
         end else if ((overflow && immediate_overflow_notify) || (fifo_pop && head_mark)) begin
            ovf_ff <= 1'b1;
         end else if (overflow_clear) begin
            ovf_ff <= 1'b0;
         end
         if (fifo_pop && head_mark) begin
            err_ff <= 1'b1;
         end else if (error_clear) begin
            err_ff <= 1'b0;
         end
      end
   end

   assign miso_o                  = miso_ff;
   assign miso_oe                 = miso_oe_ff;
   assign rx_data                 = rx_data_ff;
   assign tx_register_empty_flag  = empty_ff;
   assign receive_complete_flag   = rx_done_ff;
   assign transmit_complete_flag  = tx_done_ff;
   assign receive_overflow_status = ovf_ff;
   assign error_flag              = err_ff;
endmodule : spi_slave_link

//--- spi_slave_link_monitor.sv
// concurrent checks on the serial slave top ports
// assumes one bus clock domain, bound into every spi_slave_link
`timescale 1ns/10ps
module spi_slave_link_monitor (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [2:0] operating_mode_field,
   input wire logic       rx_enable,
   input wire logic       data_wr,
   input wire logic       data_rd,
   input wire logic       tx_done_clear,
   input wire logic       overflow_clear,
   input wire logic       error_clear,
   input wire logic       ss_b_pin,
   input wire logic       miso_oe,
   input wire logic [7:0] rx_data,
   input wire logic       tx_register_empty_flag,
   input wire logic       transmit_complete_flag,
   input wire logic       receive_overflow_status,
   input wire logic       error_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // four cycles covers the two-flop synchroniser plus the state update
   a_idle_tristate: assert property (ss_b_pin [*4] |-> !miso_oe)
      else $error("data out driven while select high");
   a_mode_off: assert property ((operating_mode_field != 3'h2) [*5] |-> !miso_oe)
      else $error("data out driven outside slave mode");
   a_wr_clears_empty: assert property (data_wr && ss_b_pin && $past(ss_b_pin, 8)
      |=> !tx_register_empty_flag)
      else $error("empty flag not cleared by write");
   a_empty_holds: assert property (!tx_register_empty_flag && ss_b_pin && $past(ss_b_pin, 8)
      |=> !tx_register_empty_flag)
      else $error("empty flag set without a load");
   a_done_on_release: assert property ($rose(ss_b_pin) && miso_oe
      |-> ##[1:5] transmit_complete_flag)
      else $error("transmit complete missing after select rise");
   a_done_sticky: assert property (transmit_complete_flag && !tx_done_clear
      |=> transmit_complete_flag)
      else $error("transmit complete dropped");
   a_receive_holding_buffer_hold: assert property (!data_rd |=> $stable(rx_data))
      else $error("read data changed without a read");
   a_ovf_sticky: assert property (receive_overflow_status && !overflow_clear && rx_enable
      |=> receive_overflow_status)
      else $error("overflow status dropped");
   a_ovf_disable: assert property (!rx_enable |=> !receive_overflow_status)
      else $error("overflow status kept while receiver off");
   a_err_sticky: assert property (error_flag && !error_clear |=> error_flag)
      else $error("error flag dropped");
   c_tx_done: cover property ($rose(transmit_complete_flag));
   c_ovf: cover property ($rose(receive_overflow_status));
   c_err: cover property ($rose(error_flag));
endmodule : spi_slave_link_monitor

bind spi_slave_link spi_slave_link_monitor spi_slave_link_monitor_inst (.clk, .rst_b,
   .operating_mode_field, .rx_enable, .data_wr, .data_rd, .tx_done_clear, .overflow_clear,
   .error_clear, .ss_b_pin, .miso_oe, .rx_data, .tx_register_empty_flag,
   .transmit_complete_flag, .receive_overflow_status, .error_flag);

//--- spi_slave_link_test.sv
// self-checking bench for the serial slave with an outside master model
// assumes spi_slave_pkg, rx_buffer_if and all design modules are compiled first
`timescale 1ns/10ps
module spi_slave_link_test;
   logic       clk = 1'b0, rst_b = 1'b0;
   logic [2:0] operating_mode_field = 3'h2;
   logic       clock_polarity = 1'b0, clock_phase = 1'b0, lsb_first = 1'b0;
   logic       immediate_overflow_notify = 1'b1, rx_enable = 1'b1;
   logic       data_wr = 1'b0, data_rd = 1'b0, rd_d = 1'b0;
   logic [7:0] data_wdata = 8'h00;
   logic       tx_done_clear = 1'b0, overflow_clear = 1'b0, error_clear = 1'b0;
   logic       ss_b_pin, sck_pin, mosi_pin, miso_o, miso_oe, rx_stb;
   logic [7:0] rx_data, rx_byte, a, m0, m1, m2;
   logic       tx_register_empty_flag, receive_complete_flag, transmit_complete_flag;
   logic       receive_overflow_status, error_flag;
   logic [8:0] eq[$], mq[$];
   int         mismatches = 0, cmp_count = 0;
   logic [31:0] rs = 32'd88;

   always #12.5 clk = ~clk;

   spi_slave_link spi_slave_link_inst (.clk, .rst_b, .operating_mode_field, .clock_polarity,
      .clock_phase, .lsb_first, .immediate_overflow_notify, .rx_enable, .data_wr, .data_wdata,
      .data_rd, .tx_done_clear, .overflow_clear, .error_clear, .ss_b_pin, .sck_pin, .mosi_pin,
      .miso_o, .miso_oe, .rx_data, .tx_register_empty_flag, .receive_complete_flag,
      .transmit_complete_flag, .receive_overflow_status, .error_flag);
   spi_master_model spi_master_model_inst (.ss_b_pin, .sck_pin, .mosi_pin, .miso_o,
      .miso_oe, .rx_byte, .rx_stb);

   function automatic logic [7:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[7:0];
   endfunction : rnd

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] v);
      @(posedge clk) data_wr <= 1'b1;
      data_wdata <= v;
      @(posedge clk) data_wr <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : wr

   // one pulse then a pause, since the complete flag lags occupancy by a clock
   task automatic rd();
      @(posedge clk) data_rd <= 1'b1;
      @(posedge clk) data_rd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : rd

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // read data is settled by the falling edge after the capturing edge
   always @(posedge clk) rd_d <= data_rd;
   always @(negedge clk) if (rd_d) check(rx_data, eq.pop_front());
   always @(posedge rx_stb) begin : miso_watch
      logic [8:0] e;
      e = mq.pop_front();
      if (!e[8]) check(rx_byte, e[7:0]);
   end

   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      check(tx_register_empty_flag, 8'h01);
      check(miso_oe, 8'h00);
      $display("test reset done");
      m0 = rnd();
      mq.push_back(9'h100);
      spi_master_model_inst.frame(1, {m0, 16'h0000});
      check(receive_complete_flag, 8'h01);
      check(transmit_complete_flag, 8'h01);
      eq.push_back({1'b0, m0});
      rd();
      @(posedge clk) tx_done_clear <= 1'b1;
      @(posedge clk) tx_done_clear <= 1'b0;
      $display("test single character done");
      a = rnd();
      m1 = rnd();
      m2 = rnd();
      wr(a);
      check(tx_register_empty_flag, 8'h00);
      mq.push_back({1'b0, m0});
      mq.push_back({1'b0, a});
      mq.push_back({1'b0, m2});
      spi_master_model_inst.frame(3, {m0 ^ 8'h5a, m2, m1});
      m0 = m0 ^ 8'h5a;
      check(receive_overflow_status, 8'h01);
      check(tx_register_empty_flag, 8'h01);
      eq.push_back({1'b0, m0});
      eq.push_back({1'b0, m2});
      rd();
      rd();
      check(receive_complete_flag, 8'h00);
      check(receive_overflow_status, 8'h01);
      @(posedge clk) overflow_clear <= 1'b1;
      @(posedge clk) overflow_clear <= 1'b0;
      @(posedge clk) #1 check(receive_overflow_status, 8'h00);
      $display("test immediate overflow done");
      immediate_overflow_notify <= 1'b0;
      m0 = rnd();
      m1 = rnd();
      for (int i = 0; i < 3; i++) mq.push_back(9'h100);
      spi_master_model_inst.frame(3, {m0, m1, 8'h3c});
      check(receive_overflow_status, 8'h00);
      eq.push_back({1'b0, m0});
      eq.push_back({1'b0, m1});
      eq.push_back(9'h000);
      rd();
      rd();
      check(error_flag, 8'h00);
      rd();
      check(receive_overflow_status, 8'h01);
      check(error_flag, 8'h01);
      check(receive_complete_flag, 8'h00);
      @(posedge clk) rx_enable <= 1'b0;
      @(posedge clk) error_clear <= 1'b1;
      @(posedge clk) error_clear <= 1'b0;
      #1 check(receive_overflow_status, 8'h00);
      check(error_flag, 8'h00);
      @(posedge clk) rx_enable <= 1'b1;
      $display("test deferred overflow done");
      @(posedge clk) tx_done_clear <= 1'b1;
      operating_mode_field <= 3'h0;
      @(posedge clk) tx_done_clear <= 1'b0;
      mq.push_back(9'h100);
      spi_master_model_inst.frame(1, {rnd(), 16'h0000});
      check(receive_complete_flag, 8'h00);
      check(transmit_complete_flag, 8'h00);
      $display("test mode off done");
      print_verdict();
   end
endmodule : spi_slave_link_test

//--- spi_slave_pkg.sv
// shared constants for the serial slave with its receive buffer
// assumes one bus clock domain; pins are synchronised before use
// How it works
// - slave idle, data out floated while select high
// - select low: sample and shift per mode
// - load into shifter sets the empty flag
// - one received character per sent; buffer same cycle
// - receive complete flag while buffer holds data
// - select rising ends transaction, sets transmit complete
// - written data ready after three serial clocks
// - late data: send previously received character instead
// - empty flag rises three bus clocks later
// - single receive error: overflow status bit
// - overflow status sticks until written one
// - receiver disabled clears overflow status
// - immediate notify raises overflow at once
// - deferred notify: marker travels, reads as zero
package spi_slave_pkg;
   localparam logic [2:0] MODE_SLAVE     = 3'h2;
   localparam int         CHAR_BITS      = 8;
   localparam logic [2:0] LAST_BIT       = 3'h7;
   localparam logic [1:0] TX_LOAD_SCK    = 2'h3;
   localparam logic [1:0] EMPTY_DELAY_CLKS = 2'h3;
   localparam logic [1:0] EMPTY_FIRE       = 2'h1;
   localparam int         CLK_PERIOD_NS  = 25;
   localparam int         SYNC_STAGES    = 2;
   localparam int         ENTRY_BITS     = CHAR_BITS + 1;
   localparam logic [CHAR_BITS-1:0] MARK_DATA = 8'h00;

   typedef enum logic [1:0] {
      LINK_IDLE   = 2'b01,
      LINK_ACTIVE = 2'b10
   } link_state_e;
endpackage : spi_slave_pkg
